// ---- rtl/mph_pkg.sv ----
// Constants and types for the motion profile and homing block
package mph_pkg;
  localparam int unsigned SAMPLE_DIV     = 200;     // Servo sample rate, 1 MHz at 200 MHz
  localparam int unsigned HOME_TMO_CYC   = 1000000; // Samples before homing gives up
  localparam int unsigned FLASH_DIV      = 65536;   // Samples per OK indicator half period
  localparam logic [8:0]  BLEND_OFF      = 9'h0B5;  // 181 degrees
  localparam logic [7:0]  PROF_TRAP      = 8'h00;
  localparam int unsigned ERR_HOME_BIT   = 7;
  typedef enum logic [2:0] {
    MPH_IDLE, MPH_ACC, MPH_CRUISE, MPH_DEC, MPH_HSEEK, MPH_HFREE, MPH_HINDEX, MPH_HSTOP
  } mph_state_e;
endpackage : mph_pkg

// ---- rtl/mph_integrator.sv ----
// Per-sample setpoint integrator: position, velocity, acceleration from jerk
`timescale 1ns/1ps
`default_nettype none
module mph_integrator #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Control
  input  wire logic                tick,
  input  wire logic                load_pos,
  input  wire logic signed [W-1:0] load_val,
  input  wire logic                hold_acc,
  input  wire logic signed [W-1:0] jerk,
  input  wire logic signed [W-1:0] acc_set,
  input  wire logic signed [W-1:0] vel_set,
  input  wire logic                vel_force,
  // Setpoints
  output logic signed [W-1:0]      pos_ff,
  output logic signed [W-1:0]      vel_ff,
  output logic signed [W-1:0]      acc_ff
);
  import mph_pkg::*;

  // Next values chain within one sample, so a ramp never overshoots by a step
  logic signed [W-1:0] nxt_acc;
  logic signed [W-1:0] nxt_vel;
  always_comb begin
    nxt_acc = hold_acc ? acc_set : acc_ff + jerk;
    nxt_vel = vel_force ? vel_set : vel_ff + nxt_acc;
  end

  // Acceleration integrates jerk unless forced to a plateau value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= '0;
    end else if (tick) begin
      acc_ff <= nxt_acc;
    end
  end

  // Velocity integrates acceleration; forced during open-loop moves
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vel_ff <= '0;
    end else if (tick) begin
      vel_ff <= nxt_vel;
    end
  end

  // Position integrates velocity, or is loaded at the reference
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_ff <= '0;
    end else if (load_pos) begin
      pos_ff <= load_val;
    end else if (tick) begin
      pos_ff <= pos_ff + nxt_vel;
    end
  end
endmodule : mph_integrator
`default_nettype wire

// ---- rtl/mph_axis.sv ----
// One axis of the motion profile generator with homing and gain latching
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mph_axis #(
  parameter int          W        = 32,
  parameter int unsigned SDIV     = mph_pkg::SAMPLE_DIV,
  parameter int unsigned HOME_TMO = mph_pkg::HOME_TMO_CYC
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  // Path context from the interpolator
  input  wire logic                path_mode,
  input  wire logic                path_any_s,
  input  wire logic [15:0]         path_ts_max,
  input  wire logic signed [W-1:0] path_axis_vel,
  input  wire logic [8:0]          seg_angle,
  input  wire logic                next_valid,
  input  wire logic signed [W-1:0] next_vel,
  // Field inputs
  input  wire logic                axis_enable,
  input  wire logic                ref_switch,
  input  wire logic                enc_index,
  input  wire logic                limit_hit,
  // Setpoints and drive
  output logic signed [W-1:0]      sp_pos,
  output logic signed [W-1:0]      sp_vel,
  output logic signed [W-1:0]      sp_acc,
  output logic signed [W-1:0]      sp_jerk,
  output logic                     open_loop,
  output logic signed [W-1:0]      open_loop_drive,
  output logic [W-1:0]             gain_bus_ff,
  output logic [3:0]               gain_sel_ff,
  output logic                     gain_upd_ff,
  output logic                     ok_led_ff,
  output logic                     homed_ff,
  output logic                     busy,
  output logic [15:0]              s_time_own
);
  import mph_pkg::*;

  // Register offsets
  localparam logic [7:0] A_CMD = 8'h00, A_DIST = 8'h04, A_VEL = 8'h08, A_ACC = 8'h0C;
  localparam logic [7:0] A_DEC = 8'h10, A_AMAX = 8'h14, A_MODE = 8'h18, A_TS = 8'h1C;
  localparam logic [7:0] A_HDIR = 8'h20, A_HVS = 8'h24, A_HFD = 8'h28, A_HVF = 8'h2C;
  localparam logic [7:0] A_REF = 8'h30, A_BLEND = 8'h34, A_STAT = 8'h38, A_POS = 8'h3C;
  localparam logic [7:0] A_GAIN = 8'h40;

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter registers
  logic signed [W-1:0] dist_ff, vel_ff, acc_ff, dec_ff, amax_ff, hvs_ff, hvf_ff, ref_ff;
  logic [7:0]  mode_ff;
  logic [15:0] ts_ff;
  logic        hdir_ff, hfd_ff;
  logic [8:0]  blend_ff;
  logic [7:0]  err_ff;
  mph_state_e  st_ff;
  logic [31:0] tmo_ff;
  logic        start_move, start_home;

  // Plain register writes; command writes start a move or homing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dist_ff <= '0; vel_ff <= '0; acc_ff <= '0; dec_ff <= '0; amax_ff <= '0;
      mode_ff <= PROF_TRAP; ts_ff <= '0; hdir_ff <= 1'b0; hfd_ff <= 1'b0;
      hvs_ff <= '0; hvf_ff <= '0; ref_ff <= '0; blend_ff <= BLEND_OFF;
    end else if (reg_wr) begin
      case (reg_addr)
        A_DIST:  dist_ff  <= reg_wdata[W-1:0];
        A_VEL:   vel_ff   <= reg_wdata[W-1:0];
        A_ACC:   acc_ff   <= reg_wdata[W-1:0];
        A_DEC:   dec_ff   <= reg_wdata[W-1:0];
        A_AMAX:  amax_ff  <= reg_wdata[W-1:0];
        A_MODE:  mode_ff  <= reg_wdata[7:0];
        A_TS:    ts_ff    <= reg_wdata[15:0];
        A_HDIR:  hdir_ff  <= reg_wdata[0];
        A_HVS:   hvs_ff   <= reg_wdata[W-1:0];
        A_HFD:   hfd_ff   <= reg_wdata[0];
        A_HVF:   hvf_ff   <= reg_wdata[W-1:0];
        A_REF:   ref_ff   <= reg_wdata[W-1:0];
        A_BLEND: blend_ff <= reg_wdata[8:0];
        default: ;
      endcase
    end
  end

  // Only one command runs at a time; command writes while busy are dropped
  assign start_move = reg_wr && reg_addr == A_CMD && reg_wdata[0] && st_ff == MPH_IDLE;
  assign start_home = reg_wr && reg_addr == A_CMD && reg_wdata[1] && st_ff == MPH_IDLE
                      && axis_enable;

  // Distance is relative: target fixed from the position at the start
  logic signed [W-1:0] tgt_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) tgt_ff <= '0;
    else if (start_move) tgt_ff <= sp_pos + dist_ff;
  end

  // Gains forwarded to the position loop the cycle after they are written
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_bus_ff <= '0; gain_sel_ff <= 4'h0; gain_upd_ff <= 1'b0;
    end else begin
      gain_upd_ff <= reg_wr && reg_addr[7:6] == 2'b01;
      if (reg_wr && reg_addr[7:6] == 2'b01) begin
        gain_bus_ff <= reg_wdata[W-1:0];
        gain_sel_ff <= reg_addr[5:2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sample tick
  logic [15:0] div_ff;
  logic        tick;
  assign tick = div_ff == 16'(SDIV - 1);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) div_ff <= 16'h0000;
    else        div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Profile arithmetic
  logic signed [W-1:0] v_tgt, a_up, a_dn, remain, brake, jerk, ramp_t;
  logic signed [W-1:0] a_plat, v_blend;
  logic [15:0]         ts_eff;
  logic                s_on, do_blend;

  // Path moves take path settings; axis limits still clamp
  always_comb begin
    v_tgt = path_mode ? path_axis_vel : vel_ff;
    if (v_tgt > vel_ff && path_mode) v_tgt = vel_ff;
    a_up = (acc_ff > amax_ff) ? amax_ff : acc_ff;
    a_dn = (dec_ff > amax_ff) ? amax_ff : dec_ff;
  end

  assign s_time_own = (mode_ff != PROF_TRAP) ? ts_ff : 16'h0000;
  // Path S-curve: any S axis forces largest segment time onto all
  assign s_on = path_mode ? path_any_s : (mode_ff != PROF_TRAP);
  // Accel time in samples; S-time clamped to half of it
  assign ramp_t = (a_up == 0) ? '0 : v_tgt / a_up;
  always_comb begin
    ts_eff = s_on ? (path_mode ? path_ts_max : ts_ff) : 16'h0000;
    if (W'(ts_eff) > (ramp_t >>> 1)) ts_eff = 16'((ramp_t >>> 1));
  end
  // Plateau raised so the ramp keeps the mean; pure S reaches twice mean
  assign a_plat = (ts_eff == 16'h0000 || ramp_t == 0) ? a_up
                  : (a_up * ramp_t) / (ramp_t - W'(ts_eff));
  assign jerk   = (ts_eff == 16'h0000) ? '0 : a_plat / W'(ts_eff);

  // Braking distance v^2/2d decides when deceleration begins
  assign remain = tgt_ff - sp_pos;
  assign brake  = (a_dn == 0) ? '0 : (sp_vel * sp_vel) / (a_dn <<< 1);
  // Blend only above angle limit, never when set to the off value
  assign do_blend = next_valid && blend_ff != BLEND_OFF && blend_ff < seg_angle;
  // Short segments: a next_vel above sqrt(2as) is not blended, v_tgt is kept instead
  logic signed [W-1:0] vmax_sq;
  assign vmax_sq = (a_up <<< 1) * remain;
  assign v_blend = !do_blend ? v_tgt
                   : (next_vel * next_vel > vmax_sq) ? v_tgt : next_vel;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  logic signed [W-1:0] jerk_sel, acc_force, v_force;
  logic                hold_a, force_v, load_p;
  logic                sw_d_ff, idx_d_ff;
  logic [31:0]         seg_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= MPH_IDLE; tmo_ff <= '0; homed_ff <= 1'b0; err_ff <= 8'h00;
      sw_d_ff <= 1'b0; idx_d_ff <= 1'b0; seg_ff <= '0;
    end else begin
      sw_d_ff  <= ref_switch;
      idx_d_ff <= enc_index;
      case (st_ff)
        MPH_IDLE: begin
          if (start_move) begin st_ff <= MPH_ACC; seg_ff <= '0; end
          if (start_home) begin
            st_ff <= MPH_HSEEK; tmo_ff <= '0; homed_ff <= 1'b0;
            err_ff[ERR_HOME_BIT] <= 1'b0;
          end
        end
        MPH_ACC: if (tick) begin
          seg_ff <= seg_ff + 32'h1;
          if (remain <= brake && !do_blend) st_ff <= MPH_DEC;
          else if (sp_vel >= v_tgt) st_ff <= MPH_CRUISE;
        end
        MPH_CRUISE: if (tick && remain <= brake) begin
          // Blend: switch velocity where braking would start
          if (do_blend) st_ff <= MPH_ACC;
          else          st_ff <= MPH_DEC;
        end
        MPH_DEC: if (tick && sp_vel <= 0) st_ff <= MPH_IDLE;
        MPH_HSEEK: if (tick) begin
          tmo_ff <= tmo_ff + 32'h1;
          if (ref_switch) st_ff <= MPH_HFREE;
          else if (tmo_ff == 32'(HOME_TMO)) begin st_ff <= MPH_IDLE; err_ff[ERR_HOME_BIT] <= 1'b1; end
        end
        MPH_HFREE: if (tick && !ref_switch) begin st_ff <= MPH_HINDEX; tmo_ff <= '0; end
        MPH_HINDEX: begin
          if (enc_index && !idx_d_ff) begin st_ff <= MPH_HSTOP; end
          else if (tick) begin
            tmo_ff <= tmo_ff + 32'h1;
            if (tmo_ff == 32'(HOME_TMO)) begin st_ff <= MPH_IDLE; err_ff[ERR_HOME_BIT] <= 1'b1; end
          end
        end
        MPH_HSTOP: if (tick && sp_vel == 0) begin st_ff <= MPH_IDLE; homed_ff <= 1'b1; end
        default: st_ff <= MPH_IDLE;
      endcase
    end
  end

  // Homing search direction flips at a limit
  logic hsdir_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) hsdir_ff <= 1'b0;
    else if (start_home) hsdir_ff <= hdir_ff;
    else if (st_ff == MPH_HSEEK && limit_hit && tick) hsdir_ff <= ~hsdir_ff;
  end

  // Per-state drive of the integrator
  always_comb begin
    jerk_sel = '0; hold_a = 1'b1; acc_force = '0; force_v = 1'b0; v_force = '0;
    load_p = 1'b0;
    case (st_ff)
      MPH_ACC: begin
        if (ts_eff != 16'h0000 && sp_acc < a_plat && (v_tgt - sp_vel) > brake) begin
          hold_a = 1'b0; jerk_sel = jerk;
        end else if (sp_vel + a_up <= v_blend) acc_force = a_up;
        else if (sp_vel - a_dn >= v_blend) acc_force = -a_dn;
        else acc_force = v_blend - sp_vel;
      end
      // Ramp down, creeping and capped by what remains so the target is hit
      MPH_DEC: begin
        force_v = 1'b1;
        v_force = (sp_vel > a_dn) ? sp_vel - a_dn : '0;
        if (v_force == '0) v_force = a_dn;
        if (v_force > remain) v_force = (remain > 0) ? remain : '0;
        acc_force = v_force - sp_vel;
      end
      MPH_HSEEK:  begin force_v = 1'b1; v_force = hsdir_ff ? -hvs_ff : hvs_ff; end
      MPH_HFREE, MPH_HINDEX: begin
        force_v = 1'b1; v_force = hfd_ff ? -hvf_ff : hvf_ff;
        load_p  = st_ff == MPH_HINDEX && enc_index && !idx_d_ff;
      end
      MPH_HSTOP:  begin force_v = 1'b1; v_force = '0; end
      default: ;
    endcase
  end

  mph_integrator #(.W(W)) u_int (
    .core_clk (core_clk), .rst_n (rst_n), .tick (tick),
    .load_pos (load_p), .load_val (ref_ff), .hold_acc (hold_a),
    .jerk (jerk_sel), .acc_set (acc_force), .vel_set (v_force), .vel_force (force_v),
    .pos_ff (sp_pos), .vel_ff (sp_vel), .acc_ff (sp_acc)
  );

  assign sp_jerk         = jerk_sel;
  assign open_loop       = st_ff inside {MPH_HSEEK, MPH_HFREE, MPH_HINDEX, MPH_HSTOP};
  assign open_loop_drive = open_loop ? sp_vel : '0;
  assign busy            = st_ff != MPH_IDLE;

  // OK indicator flashes while the homing error stands
  logic [31:0] fl_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin fl_ff <= '0; ok_led_ff <= 1'b1; end
    else if (!err_ff[ERR_HOME_BIT]) begin fl_ff <= '0; ok_led_ff <= 1'b1; end
    else if (tick) begin
      fl_ff <= (fl_ff == 32'(FLASH_DIV)) ? '0 : fl_ff + 32'h1;
      if (fl_ff == 32'(FLASH_DIV)) ok_led_ff <= ~ok_led_ff;
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 32'h0000_0000;
    else if (reg_rd) begin
      case (reg_addr)
        A_DIST:  reg_rdata <= 32'(dist_ff);
        A_VEL:   reg_rdata <= 32'(vel_ff);
        A_ACC:   reg_rdata <= 32'(acc_ff);
        A_DEC:   reg_rdata <= 32'(dec_ff);
        A_AMAX:  reg_rdata <= 32'(amax_ff);
        A_HDIR:  reg_rdata <= {31'h00000000, hdir_ff};
        A_HVS:   reg_rdata <= 32'(hvs_ff);
        A_HFD:   reg_rdata <= {31'h00000000, hfd_ff};
        A_HVF:   reg_rdata <= 32'(hvf_ff);
        A_REF:   reg_rdata <= 32'(ref_ff);
        A_MODE:  reg_rdata <= {24'h000000, mode_ff};
        A_TS:    reg_rdata <= {16'h0000, ts_ff};
        A_BLEND: reg_rdata <= {23'h000000, blend_ff};
        A_STAT:  reg_rdata <= {16'h0000, err_ff, 3'h0, homed_ff, busy, 3'(st_ff)};
        A_POS:   reg_rdata <= 32'(sp_pos);
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : mph_axis
`default_nettype wire

// ---- testbench/mph_axis_props.sv ----
// Port-level checker for one motion axis
`timescale 1ns/1ps
`default_nettype none
module mph_axis_props #(
  parameter int          W    = 32,
  parameter int unsigned SDIV = 4
) (
  // Clock, reset and register port
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic [7:0]          reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  // Context and field
  input wire logic                path_mode,
  input wire logic                axis_enable,
  // Outputs watched
  input wire logic signed [W-1:0] sp_vel,
  input wire logic signed [W-1:0] sp_jerk,
  input wire logic                open_loop,
  input wire logic [W-1:0]        gain_bus_ff,
  input wire logic [3:0]          gain_sel_ff,
  input wire logic                gain_upd_ff,
  input wire logic                homed_ff,
  input wire logic                busy,
  input wire logic [15:0]         s_time_own
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Decoded strobes
  logic gain_wr;
  logic cmd_wr;
  assign gain_wr = reg_wr && (reg_addr[7:6] == 2'h1);
  assign cmd_wr  = reg_wr && (reg_addr == 8'h00) && !busy;
  ////////////////////////////////////////////////////////////////////////////////
  // Gains land the cycle after the write, even mid-move
  gain_take_a: assert property (gain_wr |=> gain_upd_ff && gain_sel_ff == $past(reg_addr[5:2])
    && gain_bus_ff == $past(reg_wdata)) else $error("gain write not passed on");
  gain_quiet_a: assert property (!gain_wr |=> !gain_upd_ff)
    else $error("gain update without a gain write");
  move_start_a: assert property (cmd_wr && reg_wdata[0] |=> busy)
    else $error("move command did not start");
  home_refuse_a: assert property (cmd_wr && reg_wdata == 32'h2 && !axis_enable |=> !busy)
    else $error("homing started on a disabled axis");
  // Velocity setpoint only moves on the servo sample tick
  sample_hold_a: assert property ($changed(sp_vel) |=> $stable(sp_vel) [*3])
    else $error("velocity changed between sample ticks");
  open_home_a: assert property (open_loop |-> busy)
    else $error("open loop drive while idle");
  homed_stop_a: assert property ($rose(homed_ff) |-> sp_vel == '0)
    else $error("homed flag before the axis stopped");
  status_rd_a: assert property (reg_rd && reg_addr == 8'h38 |=>
    reg_rdata[4] == $past(homed_ff) && reg_rdata[3] == $past(busy)) else $error("status mismatch");
  unmapped_rd_a: assert property (reg_rd && reg_addr[7] |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  trap_jerk_a: assert property (s_time_own == 16'h0 && !path_mode |-> sp_jerk == '0)
    else $error("jerk with zero S-segment time");
  // Main scenarios reached
  cv_home: cover property ($rose(homed_ff));
  cv_gain: cover property (gain_wr);
  cv_move: cover property (cmd_wr && reg_wdata[0]);
endmodule // mph_axis_props
bind mph_axis mph_axis_props #(.W(W), .SDIV(SDIV)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .path_mode(path_mode),
  .axis_enable(axis_enable), .sp_vel(sp_vel), .sp_jerk(sp_jerk), .open_loop(open_loop),
  .gain_bus_ff(gain_bus_ff), .gain_sel_ff(gain_sel_ff), .gain_upd_ff(gain_upd_ff),
  .homed_ff(homed_ff), .busy(busy), .s_time_own(s_time_own));
`default_nettype wire

// ---- testbench/mph_field_model.sv ----
// Field-side model: reference switch, encoder index and travel limits
`timescale 1ns/1ps
`default_nettype none
module mph_field_model #(
  parameter int W = 32
) (
  // Clock and axis activity
  input  wire logic                core_clk,
  input  wire logic                open_loop,
  input  wire logic signed [W-1:0] open_loop_drive,
  input  wire logic                sw_present,
  // Field signals
  output logic                     ref_switch,
  output logic                     enc_index,
  output logic                     limit_hit
);
  logic signed [W-1:0] pos_ff = '0;
  // Homing shaft only moves open loop, one count a cycle; closed moves ignored
  always_ff @(posedge core_clk) begin
    if (!open_loop)
      pos_ff <= pos_ff;
    else if (open_loop_drive > 0)
      pos_ff <= pos_ff + 1;
    else if (open_loop_drive < 0)
      pos_ff <= pos_ff - 1;
  end
  // Switch band 40..60, index every 32 counts, limits past +-200
  assign ref_switch = sw_present && pos_ff >= 40 && pos_ff <= 60;
  assign enc_index  = pos_ff[4:0] < 5'h04;
  assign limit_hit  = pos_ff > 200 || pos_ff < -200;
endmodule // mph_field_model
`default_nettype wire

// ---- testbench/motion_profile_homing_tb_top.sv ----
// Self-checking bench for one motion axis
`timescale 1ns/1ps
`default_nettype none
module motion_profile_homing_tb_top;
  import mph_pkg::*;
  localparam int W = 32;
  logic                core_clk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, path_mode, path_any_s;
  logic                next_valid, axis_enable, sw_present, ref_switch, enc_index, limit_hit;
  logic                open_loop, gain_upd_ff, ok_led_ff, homed_ff, busy, b0, jk, ol;
  logic [7:0]          reg_addr;
  logic [31:0]         reg_wdata, reg_rdata, d;
  logic [15:0]         path_ts_max, s_time_own;
  logic [8:0]          seg_angle;
  logic [3:0]          gain_sel_ff;
  logic [W-1:0]        gain_bus_ff;
  logic signed [W-1:0] path_axis_vel, next_vel, sp_pos, sp_vel, sp_acc, sp_jerk;
  logic signed [W-1:0] open_loop_drive, pk;
  int                  n_mismatch = 0, cmp_count = 0;
  // Register rows: address, value written, value read back
  logic [71:0] rows [13] = '{{8'h04, 32'd100, 32'd100}, {8'h08, 32'd5, 32'd5},
    {8'h0C, 32'd1, 32'd1}, {8'h10, 32'd1, 32'd1}, {8'h14, 32'd10, 32'd10}, {8'h18, 32'd0, 32'd0},
    {8'h1C, 32'd0, 32'd0}, {8'h20, 32'd0, 32'd0}, {8'h24, 32'd1, 32'd1}, {8'h28, 32'd1, 32'd1},
    {8'h2C, 32'd1, 32'd1}, {8'h30, 32'd7, 32'd7}, {8'h34, 32'h0B5, 32'h0B5}};
  ////////////////////////////////////////////////////////////////////////////////
  // Design, field model, 200 MHz clock
  mph_axis #(.W(W), .SDIV(4), .HOME_TMO(500)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .path_mode(path_mode), .path_any_s(path_any_s),
    .path_ts_max(path_ts_max), .path_axis_vel(path_axis_vel), .seg_angle(seg_angle),
    .next_valid(next_valid), .next_vel(next_vel), .axis_enable(axis_enable),
    .ref_switch(ref_switch), .enc_index(enc_index), .limit_hit(limit_hit), .sp_pos(sp_pos),
    .sp_vel(sp_vel), .sp_acc(sp_acc), .sp_jerk(sp_jerk), .open_loop(open_loop),
    .open_loop_drive(open_loop_drive), .gain_bus_ff(gain_bus_ff), .gain_sel_ff(gain_sel_ff),
    .gain_upd_ff(gain_upd_ff), .ok_led_ff(ok_led_ff), .homed_ff(homed_ff), .busy(busy),
    .s_time_own(s_time_own));
  mph_field_model #(.W(W)) u_field (.core_clk(core_clk), .open_loop(open_loop),
    .open_loop_drive(open_loop_drive), .sw_present(sw_present), .ref_switch(ref_switch),
    .enc_index(enc_index), .limit_hit(limit_hit));
  always #2.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus cycles, command runner, verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Bounded wait for idle while noting peak speed, jerk and open-loop drive
  task automatic run(input logic [31:0] cmd);
    wr(8'h00, cmd);
    #1 b0 = busy;
    pk = '0;
    jk = 1'b0;
    ol = 1'b0;
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) begin
      @(posedge core_clk);
      #1 if (sp_vel > pk) pk = sp_vel;
      if (sp_jerk !== '0) jk = 1'b1;
      if (open_loop === 1'b1) ol = 1'b1;
    end
  endtask
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; no blending wanted, so the next segment stays invalid
  initial begin
    {reg_wr, reg_rd, path_mode, path_any_s, next_valid, axis_enable} = '0;
    {reg_addr, reg_wdata, path_ts_max, path_axis_vel, next_vel} = '0;
    seg_angle = 9'h05A;
    sw_present = 1'b1;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk("ok_led", ok_led_ff, 1'b1);
    rd(8'h34, d);
    chk("blend_rst", d, 32'h0B5);
    for (int k = 0; k < 13; k++) begin
      wr(rows[k][71:64], rows[k][63:32]);
      rd(rows[k][71:64], d);
      chk("reg_rb", d, rows[k][31:0]);
    end
    rd(8'h80, d);
    chk("unmapped", d, 32'h0);
    run(32'h1);
    chk("busy_start", b0, 1'b1);
    chk("trap_pos", sp_pos, 32'd100);
    chk("trap_peak", pk, 32'd5);
    wr(8'h08, 32'd100);
    wr(8'h04, 32'd10);
    run(32'h1);
    chk("tri_peak", pk < 100, 1'b1);
    chk("tri_pos", sp_pos, 32'd110);
    wr(8'h08, 32'd5);
    wr(8'h04, 32'd100);
    wr(8'h18, 32'd1);
    wr(8'h1C, 32'd1);
    run(32'h1);
    chk("s_jerk", jk, 1'b1);
    chk("s_pos", sp_pos, 32'd210);
    wr(8'h1C, 32'd0);
    run(32'h1);
    chk("s0_jerk", jk, 1'b0);
    wr(8'h18, 32'd0);
    @(posedge core_clk);
    {path_mode, path_any_s} <= 2'h3;
    path_ts_max <= 16'h0001;
    path_axis_vel <= 32'sd3;
    run(32'h1);
    chk("path_peak", pk, 32'd3);
    chk("path_jerk", jk, 1'b1);
    {path_mode, path_any_s} <= 2'h0;
    wr(8'h00, 32'h1);
    wr(8'h48, 32'h1234_5678);
    #1 chk("gain_upd", gain_upd_ff, 1'b1);
    chk("gain_sel", gain_sel_ff, 4'h2);
    chk("gain_bus", gain_bus_ff, 32'h1234_5678);
    run(32'h0);
    chk("move_pos", sp_pos, 32'd510);
    wr(8'h00, 32'h2);
    #1 chk("home_refused", busy, 1'b0);
    @(posedge core_clk);
    axis_enable <= 1'b1;
    run(32'h2);
    chk("homed", homed_ff, 1'b1);
    chk("open_loop", ol, 1'b1);
    rd(8'h38, d);
    chk("stat_homed", d[4], 1'b1);
    @(posedge core_clk);
    sw_present <= 1'b0;
    run(32'h2);
    rd(8'h38, d);
    chk("home_err", d[15], 1'b1);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk("rst_homed", homed_ff, 1'b0);
    chk("rst_busy", busy, 1'b0);
    final_report();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    final_report();
  end
endmodule // motion_profile_homing_tb_top
`default_nettype wire
